// ### rtl/shac_params.svh
// Constants for the sample-and-hold acquire control block
// Behaviour
// - Channel selection is accepted from whichever port, serial or parallel, is active.
// - Loaded selection with track high starts acquiring a code matching the input.
// - Busy goes low when acquisition starts and stays low until it ends.
// - A single-channel acquisition completes within 16 microseconds of its start.
// - During acquisition the input is routed to the selected channel's output buffer.
// - At completion busy returns high and the new DAC code drives the buffer.
// - A stored code stays unchanged until that same channel is selected again.
// - Power-on clears every DAC code, offset channel included, to zero.
// - An extra offset channel acquires like others and drives the offset output.
// - A low pulse of 50 to 150 ns on track/reset resets everything except the serial/parallel mode bit.
// - A track/reset low pulse shorter than 50 ns is ignored as a glitch.
// - Track low beyond 150 ns passes the input through for the selected channel.
// - In track-low mode acquisition waits for the next rising track edge.
// - While track is low the selected stage input connects to the common input.
// - Active-high offset select directs the selection to the offset channel.
// - The all-channel acquire input makes all 32 channels acquire together.
`ifndef SHAC_PARAMS_SVH
`define SHAC_PARAMS_SVH

`define SHAC_CLK_MHZ 100
`define SHAC_ACQ_US 16
`define SHAC_ACQ_CYC (`SHAC_ACQ_US * `SHAC_CLK_MHZ)
`define SHAC_GLITCH_NS 50
`define SHAC_GLITCH_CYC ((`SHAC_GLITCH_NS * `SHAC_CLK_MHZ + 999) / 1000)
`define SHAC_RST_MAX_NS 150
`define SHAC_RST_MAX_CYC ((`SHAC_RST_MAX_NS * `SHAC_CLK_MHZ) / 1000)

`define SHAC_CODE_W 14
`define SHAC_NCH 32
`define SHAC_CODE_RST 14'h0000

`define SHAC_A_CTRL 32'h00000000
`define SHAC_A_STAT 32'h00000004
`define SHAC_A_CODE 32'h00000008
`define SHAC_A_SAR 32'h0000000C

`define SHAC_CTRL_ADDR_LSB 0
`define SHAC_CTRL_OFFS_BIT 5
`define SHAC_CTRL_ALL_BIT 6
`define SHAC_CTRL_SER_BIT 7
`define SHAC_STAT_BUSY_BIT 0
`define SHAC_STAT_TRKLO_BIT 1

`endif

// ### rtl/shac_pkg.sv
// Types for the sample-and-hold acquire control block
package shac_pkg;
	typedef enum logic [1:0] {
		SHAC_IDLE = 2'b00,
		SHAC_WAIT = 2'b01,
		SHAC_ACQ = 2'b10
	} shac_state_t;

	typedef enum logic [1:0] {
		SHAC_PW_HIGH = 2'b00,
		SHAC_PW_LOW = 2'b01,
		SHAC_PW_TRACK = 2'b10
	} shac_pw_t;

	typedef logic [13:0] shac_code_t;
endpackage

// ### rtl/shac_sel_if.sv
// Track event carrier between the control core and the pulse classifier
interface shac_sel_if;
	logic track_high;
	logic track_low_mode;
	logic track_rise;
	logic pulse_reset;

	modport classifier (output track_high, track_low_mode, track_rise,
		pulse_reset);
	modport core (input track_high, track_low_mode, track_rise,
		pulse_reset);
endinterface

// ### rtl/shac_pulse_classify.sv
// Track/reset pin pulse-width classifier
`include "shac_params.svh"

module shac_pulse_classify (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic track_reset_pin, // Shared track/reset pin
	shac_sel_if.classifier sel // Classified track events
);
	localparam int unsigned GL = `SHAC_GLITCH_CYC;
	localparam int unsigned RM = `SHAC_RST_MAX_CYC;

	shac_pkg::shac_pw_t st;
	logic [7:0] width;
	logic pin_q;

	// Low-width counter; saturates at 8'hFF
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			width <= 8'h00;
		end else if (track_reset_pin) begin
			width <= 8'h00;
		end else if (width != 8'hFF) begin
			width <= width + 8'h01;
		end
	end

	// Width class: high, low-short, or track-low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= shac_pkg::SHAC_PW_HIGH;
			pin_q <= 1'b1;
			sel.pulse_reset <= 1'b0;
			sel.track_rise <= 1'b0;
		end else begin
			pin_q <= track_reset_pin;
			sel.pulse_reset <= 1'b0;
			sel.track_rise <= 1'b0;
			case (st)
				shac_pkg::SHAC_PW_HIGH: begin
					if (!track_reset_pin)
						st <= shac_pkg::SHAC_PW_LOW;
				end
				shac_pkg::SHAC_PW_LOW: begin
					// At the rise, width holds the low samples seen
					if (track_reset_pin) begin
						st <= shac_pkg::SHAC_PW_HIGH;
						if (32'(width) >= GL)
							sel.pulse_reset <= 1'b1;
					end else if (32'(width) + 32'd1 > RM) begin
						st <= shac_pkg::SHAC_PW_TRACK;
					end
				end
				shac_pkg::SHAC_PW_TRACK: begin
					if (track_reset_pin) begin
						st <= shac_pkg::SHAC_PW_HIGH;
						sel.track_rise <= 1'b1;
					end
				end
				default: st <= shac_pkg::SHAC_PW_HIGH;
			endcase
		end
	end

	// Short lows still count as high: they may yet prove to be glitches
	assign sel.track_high = (st != shac_pkg::SHAC_PW_TRACK);
	assign sel.track_low_mode = (st == shac_pkg::SHAC_PW_TRACK);
endmodule // shac_pulse_classify

// ### rtl/shac_top.sv
// Sample-and-hold acquisition control with AHB-Lite register access
//
// The address map and the AHB-Lite register port were decided locally.
`include "shac_params.svh"

module shac_top (
	input wire logic hclk, // System clock, 100 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response, always OKAY
	input wire logic par_load, // Parallel port load strobe
	input wire logic [4:0] par_channel_address_lines, // Parallel address
	input wire logic par_offset_sel, // Parallel offset select
	input wire logic par_all, // Parallel all-channel acquire
	input wire logic track_reset_pin, // Shared track/reset pin
	input wire logic comparator_above, // Converter compare: input >= trial
	output logic busy_n, // Busy, low while acquiring
	output logic [31:0] pass_through, // Per channel: buffer follows input
	output logic offset_pass_through, // Offset buffer follows input
	output logic [13:0] trial_code, // Trial code to converter DAC
	output logic [447:0] channel_output, // 32 held codes, channel 0 low
	output logic [13:0] offset_channel_output // Held offset code
);
	localparam int unsigned ACQ = `SHAC_ACQ_CYC;
	localparam int unsigned W = `SHAC_CODE_W;
	// Approximation steps spread evenly over the acquisition window
	localparam logic [10:0] STEP = 11'(ACQ / (W + 1));

	shac_sel_if sel();

	shac_pulse_classify u_cls (
		.hclk(hclk),
		.hresetn(hresetn),
		.track_reset_pin(track_reset_pin),
		.sel(sel)
	);

	shac_pkg::shac_state_t state;
	shac_pkg::shac_code_t code [0:`SHAC_NCH-1];
	shac_pkg::shac_code_t offs_code;
	logic [4:0] sel_ch;
	logic sel_offs;
	logic sel_all;
	logic ser_mode;
	logic ser_load;
	logic [4:0] ser_ch;
	logic ser_offs;
	logic ser_all;
	logic [10:0] step_cnt;
	logic [3:0] bit_idx;
	logic [13:0] sar;
	logic aph_wr;
	logic [3:0] aph_idx;
	logic load_req;
	logic [4:0] req_ch;
	logic req_offs;
	logic req_all;
	logic soft_rst;
	logic [31:0] next_hrdata;
	logic step_tick;

	// Port selection follows the serial/parallel mode bit
	always_comb begin
		load_req = ser_mode ? ser_load : par_load;
		req_ch = ser_mode ? ser_ch : par_channel_address_lines;
		req_offs = ser_mode ? ser_offs : par_offset_sel;
		req_all = ser_mode ? ser_all : par_all;
	end

	assign soft_rst = sel.pulse_reset;
	assign step_tick = (step_cnt == 11'd0);

	// AHB address phase capture; the slave never stalls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_wr <= 1'b0;
			aph_idx <= 4'h0;
		end else if (hready) begin
			aph_wr <= hsel & htrans[1] & hwrite;
			aph_idx <= haddr[5:2];
		end
	end

	// Control register writes: mode and serial-port selection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ser_mode <= 1'b0;
			ser_load <= 1'b0;
			ser_ch <= 5'h00;
			ser_offs <= 1'b0;
			ser_all <= 1'b0;
		end else begin
			ser_load <= 1'b0;
			if (soft_rst) begin
				ser_ch <= 5'h00;
				ser_offs <= 1'b0;
				ser_all <= 1'b0;
			end else if (aph_wr && {aph_idx, 2'b00} == 6'(`SHAC_A_CTRL)) begin
				ser_ch <= hwdata[`SHAC_CTRL_ADDR_LSB +: 5];
				ser_offs <= hwdata[`SHAC_CTRL_OFFS_BIT];
				ser_all <= hwdata[`SHAC_CTRL_ALL_BIT];
				ser_mode <= hwdata[`SHAC_CTRL_SER_BIT];
				ser_load <= hwdata[`SHAC_CTRL_SER_BIT];
			end
		end
	end

	// Read mux on the address phase, so data stands in the data phase
	always_comb begin
		next_hrdata = 32'h00000000;
		case ({haddr[5:2], 2'b00})
			6'(`SHAC_A_CTRL):
				next_hrdata = {24'h000000, ser_mode, ser_all, ser_offs, ser_ch};
			6'(`SHAC_A_STAT):
				next_hrdata = {30'h00000000, sel.track_low_mode, busy_n};
			6'(`SHAC_A_CODE):
				next_hrdata = {18'h00000, sel_offs ? offs_code : code[sel_ch]};
			6'(`SHAC_A_SAR):
				next_hrdata = {18'h00000, sar};
			default: next_hrdata = 32'h00000000;
		endcase
	end

	// Read data register, loaded at the end of the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite)
				hrdata <= next_hrdata;
		end
	end

	// Acquisition sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= shac_pkg::SHAC_IDLE;
			sel_ch <= 5'h00;
			sel_offs <= 1'b0;
			sel_all <= 1'b0;
			busy_n <= 1'b1;
		end else if (soft_rst) begin
			state <= shac_pkg::SHAC_IDLE;
			sel_ch <= 5'h00;
			sel_offs <= 1'b0;
			sel_all <= 1'b0;
			busy_n <= 1'b1;
		end else begin
			case (state)
				shac_pkg::SHAC_IDLE, shac_pkg::SHAC_WAIT: begin
					// New loads are taken only while not acquiring
					if (load_req) begin
						sel_ch <= req_ch;
						sel_offs <= req_offs;
						sel_all <= req_all;
						if (sel.track_high) begin
							state <= shac_pkg::SHAC_ACQ;
							busy_n <= 1'b0;
						end else begin
							state <= shac_pkg::SHAC_WAIT;
						end
					end else if (state == shac_pkg::SHAC_WAIT &&
						sel.track_rise) begin
						state <= shac_pkg::SHAC_ACQ;
						busy_n <= 1'b0;
					end
				end
				shac_pkg::SHAC_ACQ: begin
					// Loads here are dropped
					if (step_tick && bit_idx == 4'd0) begin
						state <= shac_pkg::SHAC_IDLE;
						busy_n <= 1'b1;
					end
				end
				default: state <= shac_pkg::SHAC_IDLE;
			endcase
		end
	end

	// Successive approximation; whole run fits the acquisition limit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			step_cnt <= STEP;
			bit_idx <= 4'd13;
			sar <= 14'h0000;
			trial_code <= 14'h2000;
		end else if (state != shac_pkg::SHAC_ACQ || soft_rst) begin
			step_cnt <= STEP;
			bit_idx <= 4'd13;
			sar <= 14'h0000;
			trial_code <= 14'h2000;
		end else if (!step_tick) begin
			step_cnt <= step_cnt - 11'd1;
		end else begin
			step_cnt <= STEP;
			sar[bit_idx] <= comparator_above;
			if (bit_idx != 4'd0) begin
				bit_idx <= bit_idx - 4'd1;
				trial_code <= (trial_code & ~(14'h0001 << bit_idx)) |
					({13'h0000, comparator_above} << bit_idx) |
					(14'h0001 << (bit_idx - 4'd1));
			end
		end
	end

	// Per-channel code store and buffer routing
	genvar g;
	generate
		for (g = 0; g < `SHAC_NCH; g = g + 1) begin : g_ch
			logic hit;
			assign hit = (sel_all || (!sel_offs && sel_ch == 5'(g)));
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					code[g] <= `SHAC_CODE_RST;
					pass_through[g] <= 1'b0;
				end else if (soft_rst) begin
					code[g] <= `SHAC_CODE_RST;
					pass_through[g] <= 1'b0;
				end else begin
					// Only the addressed channel, or every channel when sel_all is set, is touched
					if (state == shac_pkg::SHAC_ACQ && step_tick &&
						bit_idx == 4'd0 && hit)
						code[g] <= {sar[13:1], comparator_above};
					pass_through[g] <= hit &&
						(state == shac_pkg::SHAC_ACQ ||
						sel.track_low_mode);
				end
			end
			assign channel_output[g*W +: W] = code[g];
		end
	endgenerate

	// Offset channel acquires like any other
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			offs_code <= `SHAC_CODE_RST;
			offset_pass_through <= 1'b0;
		end else if (soft_rst) begin
			offs_code <= `SHAC_CODE_RST;
			offset_pass_through <= 1'b0;
		end else begin
			if (state == shac_pkg::SHAC_ACQ && step_tick &&
				bit_idx == 4'd0 && sel_offs && !sel_all)
				offs_code <= {sar[13:1], comparator_above};
			offset_pass_through <= sel_offs && !sel_all &&
				(state == shac_pkg::SHAC_ACQ || sel.track_low_mode);
		end
	end

	assign offset_channel_output = offs_code;
endmodule // shac_top

// ### dv/shac_comp_model.sv
// Converter comparator model on the block's far side
module shac_comp_model (
	input wire logic [13:0] trial_code, // Trial code from block
	input wire logic [13:0] level, // Common input as a code
	output logic comparator_above // Input at or above trial
);
	timeunit 1ns;
	timeprecision 1ps;
	// Ideal compare, so the search must land on level exactly
	assign comparator_above = (level >= trial_code);
endmodule // shac_comp_model

// ### dv/shac_top_monitor.sv
// Port checker for the acquire control top
module shac_monitor (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Response
	input wire logic track_reset_pin, // Track/reset pin
	input wire logic busy_n, // Busy, active low
	input wire logic [31:0] pass_through, // Channel follows input
	input wire logic offset_pass_through, // Offset follows input
	input wire logic [447:0] channel_output, // Held codes
	input wire logic [13:0] offset_channel_output // Held offset code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] low_cnt;
	logic [10:0] busy_cnt;
	// Cycles spent busy; too long a window for a delay range
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_cnt <= 11'h000;
		end else if (busy_n) begin
			busy_cnt <= 11'h000;
		end else if (busy_cnt != 11'h7FF) begin
			busy_cnt <= busy_cnt + 11'h001;
		end
	end
	// Low samples on the pin; saturates so long holds stay long
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt <= 8'h00;
		end else if (track_reset_pin) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'hFF) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	acq_bound_a: assert property (busy_cnt <= 11'd1600)
		else $error("acquisition longer than 16 us");
	follow_busy_a: assert property (!busy_n && !$past(busy_n)
		|-> (pass_through != 32'h0) || offset_pass_through)
		else $error("no buffer follows input while busy");
	hand_back_a: assert property ($rose(busy_n) |-> ##[0:1]
		(pass_through == 32'h0 && !offset_pass_through))
		else $error("buffer still follows input after busy");
	codes_held_a: assert property (busy_n && $past(busy_n)
		&& $past(busy_n, 2) |-> $stable(channel_output)
		|| channel_output == 448'h0)
		else $error("held code changed while idle");
	offset_held_a: assert property (busy_n && $past(busy_n)
		&& $past(busy_n, 2) |-> $stable(offset_channel_output)
		|| offset_channel_output == 14'h0000)
		else $error("offset code changed while idle");
	reset_zero_a: assert property ($rose(hresetn) |->
		channel_output == 448'h0 && offset_channel_output == 14'h0000)
		else $error("codes not zero after power-on");
	pin_reset_a: assert property (track_reset_pin && low_cnt >= 8'h05
		&& low_cnt <= 8'h0F |-> ##[1:3] (channel_output == 448'h0
		&& offset_channel_output == 14'h0000))
		else $error("pin reset pulse did not clear codes");
	glitch_a: assert property (track_reset_pin && busy_n
		&& low_cnt >= 8'h01 && low_cnt <= 8'h04
		|=> $stable(channel_output)[*3])
		else $error("short pin glitch changed codes");
endmodule // shac_monitor
bind shac_top shac_monitor shac_monitor_i (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .busy_n(busy_n),
	.track_reset_pin(track_reset_pin), .pass_through(pass_through),
	.offset_pass_through(offset_pass_through),
	.channel_output(channel_output),
	.offset_channel_output(offset_channel_output));

// ### dv/tb_sample_hold_acquire_control.sv
// Self-checking bench for the acquire control top
`include "shac_params.svh"
module tb_sample_hold_acquire_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic hreadyout, hresp, busy_n, offset_pass_through, cmp, rd_ph = 1'b0;
	logic par_load = 1'b0, par_offset_sel = 1'b0, par_all = 1'b0;
	logic track_reset_pin = 1'b1;
	logic [4:0] par_channel_address_lines = 5'h00;
	logic [31:0] pass_through;
	logic [13:0] trial_code, offset_channel_output, level = 14'h0000, t;
	logic [447:0] channel_output;
	logic [13:0] expc [33];
	logic [31:0] exp_q [$];
	int bad_count = 0, compares = 0, c;
	shac_top shac_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .par_load(par_load),
		.par_channel_address_lines(par_channel_address_lines),
		.par_offset_sel(par_offset_sel), .par_all(par_all),
		.track_reset_pin(track_reset_pin), .comparator_above(cmp),
		.busy_n(busy_n), .pass_through(pass_through),
		.offset_pass_through(offset_pass_through), .trial_code(trial_code),
		.channel_output(channel_output),
		.offset_channel_output(offset_channel_output));
	shac_comp_model shac_comp_model_i (.trial_code(trial_code),
		.level(level), .comparator_above(cmp));
	always #5 hclk = ~hclk;
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, s);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [13:0] code_of(input int k);
		return (k == 32) ? offset_channel_output : channel_output[14*k +: 14];
	endfunction
	// Oldest read note is matched against the data phase result
	always @(posedge hclk) begin
		if (rd_ph && hreadyout) check("hrdata", exp_q.pop_front(), hrdata);
		rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	// Bounded wait on a level of ready or busy
	task automatic waitv(input bit rdy, input logic v, input int lim);
		int n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((rdy ? hreadyout : busy_n) !== v && n < lim);
		if (n >= lim) begin
			bad_count++;
			conclude();
		end
	endtask
	// One single-word transfer; a read notes d as its expected data
	task automatic bus(input logic w, input logic [31:0] a, d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		waitv(1'b1, 1'b1, 50);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		if (!w) exp_q.push_back(d);
		waitv(1'b1, 1'b1, 50);
	endtask
	task automatic acq(input logic [31:0] v, input logic [13:0] x);
		level <= x;
		bus(1'b1, `SHAC_A_CTRL, v);
		waitv(1'b0, 1'b0, 20);
		waitv(1'b0, 1'b1, 1610);
	endtask
	task automatic held();
		for (int j = 0; j < 33; j++) check("held", 32'(expc[j]), 32'(code_of(j)));
	endtask
	task automatic pin_low(input int n);
		track_reset_pin <= 1'b0;
		repeat (n) @(posedge hclk);
		track_reset_pin <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask
	initial begin
		void'($urandom(32877));
		foreach (expc[j]) expc[j] = 14'h0000;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, `SHAC_A_CODE, 32'h0);
		bus(1'b0, `SHAC_A_STAT, 32'h1);
		bus(1'b0, 32'h00000010, 32'h0);
		// Corner channels, a random one and the offset channel
		for (int i = 0; i < 4; i++) begin
			c = (i == 0) ? 0 : (i == 1) ? 31 : (i == 2) ? $urandom % 31 : 32;
			t = 14'($urandom);
			expc[c] = t;
			acq(32'h80 | ((c == 32) ? 32'h20 : 32'(c)), t);
			check("code", 32'(t), 32'(code_of(c)));
			if (c < 32) bus(1'b0, `SHAC_A_CODE, 32'(t));
		end
		held();
		// A load during busy is dropped
		t = 14'($urandom);
		expc[7] = t;
		level <= t;
		bus(1'b1, `SHAC_A_CTRL, 32'h87);
		waitv(1'b0, 1'b0, 20);
		bus(1'b1, `SHAC_A_CTRL, 32'h88);
		waitv(1'b0, 1'b1, 1610);
		repeat (30) @(posedge hclk);
		check("busy", 32'h1, 32'(busy_n));
		held();
		t = 14'($urandom);
		acq(32'hC0, t);
		for (int j = 0; j < 32; j++) expc[j] = t;
		held();
		pin_low(4);
		held();
		pin_low(10);
		foreach (expc[j]) expc[j] = 14'h0000;
		held();
		// Track held low: input passes until the pin rises
		track_reset_pin <= 1'b0;
		repeat (30) @(posedge hclk);
		t = 14'($urandom);
		level <= t;
		bus(1'b1, `SHAC_A_CTRL, 32'h83);
		repeat (20) @(posedge hclk);
		check("pass", 32'h1, {31'h0, pass_through[3]});
		track_reset_pin <= 1'b1;
		waitv(1'b0, 1'b0, 20);
		waitv(1'b0, 1'b1, 1610);
		check("track", 32'(t), 32'(code_of(3)));
		// Parallel port load
		bus(1'b1, `SHAC_A_CTRL, 32'h0);
		t = 14'($urandom);
		level <= t;
		par_channel_address_lines <= 5'h05;
		par_load <= 1'b1;
		@(posedge hclk);
		par_load <= 1'b0;
		waitv(1'b0, 1'b0, 20);
		waitv(1'b0, 1'b1, 1610);
		check("par", 32'(t), 32'(code_of(5)));
		conclude();
	end
endmodule // tb_sample_hold_acquire_control
